//--- logic/phase_overcurrent_stages.sv
// Four-stage phase overcurrent pickup and trip decision
//
// Summary of operation
// - Four stages; stages three, four may be inverse
// - Disabled stage gives no pickup or trip
// - Each present phase has own element
// - Pickup and trip per phase and stage
// - Stage pickup and trip are phase ORs
// - Threshold per unit, scaled by rated current
// - Definite pickup above threshold, drop below 96%
// - Fixed trip delay; zero trips at once
// - Dropout delay holds state; zero resets at once
// - After trip, reset immediately on drop
// - Inverse pickup above 1.04, reset below threshold
// - Per-stage ANSI or IEC curve equations
// - Inverse delay integrated while picked up
// - Start level gates pickup; max time bounds curve
// - Time multiplier scales; minimum time floor
// - Reset instant or inverse, per stage
// - Inverse reset unwinds accumulated state gradually
// - Inverse reset uses same multiplier, integrated
// - Stage and general inhibits, reported per stage
`default_nettype none

module phase_overcurrent_stages
  import overcurrent_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [NUM_PHASES-1:0][MAG_W-1:0] i_phase_mag,
  input wire logic [NUM_PHASES-1:0] i_phase_present,
  input wire logic [MAG_W-1:0] i_rated_current,
  input wire stage_cfg_t i_stage_cfg [NUM_STAGES],
  input wire logic i_general_inhibit,
  input wire logic i_stage_one_inhibit,
  input wire logic i_stage_two_inhibit,
  input wire logic i_stage_three_inhibit,
  input wire logic i_stage_four_inhibit,
  output logic [NUM_STAGES-1:0][NUM_PHASES-1:0] o_phase_pickup,
  output logic [NUM_STAGES-1:0][NUM_PHASES-1:0] o_phase_trip,
  output logic [NUM_STAGES-1:0] o_stage_pickup,
  output logic [NUM_STAGES-1:0] o_stage_trip,
  output logic [NUM_STAGES-1:0] o_stage_inhibited_flag
);

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  // ==========================================================
  // Evaluation tick prescaler
  logic [PRE_W-1:0] pre_r;
  logic tick;

  assign tick = (pre_r == PRE_LAST);

  always_ff @(posedge i_clock)
  begin
    if (i_reset || tick)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  end

  // ==========================================================
  // Inhibits
  logic [NUM_STAGES-1:0] stage_inh;

  assign stage_inh = {i_stage_four_inhibit, i_stage_three_inhibit,
                      i_stage_two_inhibit, i_stage_one_inhibit};
  assign o_stage_inhibited_flag = stage_inh | {NUM_STAGES{i_general_inhibit}};

  // ==========================================================
  // Stages
  genvar s, p;
  generate
    for (s = 0; s < NUM_STAGES; s++)
    begin : g_stage
      stage_cfg_t cfg;
      curve_t curve_eff;
      curve_coef_t coef;
      logic inverse;
      logic active;
      logic inst_reset;
      logic [MAG_W+PU_W-1:0] iop_full;
      logic [MAG_W+PU_W-1:0] start_full;
      logic [IOP_W-1:0] iop;
      logic [IOP_W-1:0] start_amp;
      logic [SQ_W-1:0] iop2;
      logic [IOP_W+7:0] iop_rst;
      logic [IOP_W+7:0] iop_inv;
      logic [ACC_W-1:0] thr_base;

      assign cfg = i_stage_cfg[s];
      assign curve_eff = (s < 2) ? CURVE_DEFINITE : cfg.stage_curve_select;
      assign inverse = (curve_eff != CURVE_DEFINITE);
      assign coef = curve_coef(curve_eff);
      assign active = cfg.stage_enable_setting && !o_stage_inhibited_flag[s];
      assign inst_reset = (cfg.stage_reset_type == RESET_INSTANT);
      assign iop_full = i_rated_current * cfg.pickup_pu;
      assign start_full = i_rated_current * cfg.stage_start_current;
      assign iop = iop_full[MAG_W+PU_W-1:PU_FRAC];
      assign start_amp = start_full[MAG_W+PU_W-1:PU_FRAC];
      assign iop2 = iop * iop;
      assign iop_rst = iop * DT_RESET_PCT;
      assign iop_inv = iop * INV_PICKUP_PCT;
      // IEC: sum of 10x reaches A*TM*Iop^2
      assign thr_base = coef.a_c * cfg.stage_time_multiplier * iop2;

      for (p = 0; p < NUM_PHASES; p++)
      begin : g_phase
        logic [IOP_W-1:0] mag;
        logic [IOP_W+7:0] mag_pct;
        logic [SQ_W-1:0] mag2;
        logic [SQ_W-1:0] x;
        logic [SQ_W-1:0] y;
        logic [ACC_W-1:0] inc;
        logic [ACC_W-1:0] thr;
        logic [ACC_W-1:0] dec_full;
        logic [ACC_W-1:0] dec;
        logic above;
        logic below;
        logic inv_start;
        logic [TIME_W:0] tmr_inc;
        logic [TIME_W:0] dcnt_inc;
        logic pick_r;
        logic pick_nxt;
        logic pu_r;
        logic pu_nxt;
        logic trip_r;
        logic trip_nxt;
        logic [TIME_W-1:0] tmr_r;
        logic [TIME_W-1:0] tmr_nxt;
        logic [TIME_W-1:0] dcnt_r;
        logic [TIME_W-1:0] dcnt_nxt;
        logic [ACC_W-1:0] acc_r;
        logic [ACC_W-1:0] acc_nxt;

        assign mag = IOP_W'(i_phase_mag[p]);
        assign mag_pct = mag * PCT_SCALE;
        assign mag2 = mag * mag;
        assign above = (mag > iop);
        assign below = (mag_pct < iop_rst);
        assign inv_start = (mag_pct > iop_inv);
        assign x = above ? (mag2 - iop2) : '0;
        assign y = (mag < iop) ? (iop2 - mag2) : '0;
        assign inc = x * X_SCALE;
        // ANSI adds the B term at the present current
        assign thr = thr_base + coef.b_c * x * cfg.stage_time_multiplier;
        assign dec_full = y * coef.r_c;
        assign dec = dec_full >> COEF_FRAC;
        assign tmr_inc = {1'b0, tmr_r} + 1'b1;
        assign dcnt_inc = {1'b0, dcnt_r} + 1'b1;

        always_comb
        begin
          pick_nxt = pick_r;
          trip_nxt = trip_r;
          tmr_nxt = tmr_r;
          dcnt_nxt = dcnt_r;
          acc_nxt = acc_r;
          if (!active || !i_phase_present[p])
          begin
            // Disabled, inhibited or absent phase
            pick_nxt = 1'b0;
            trip_nxt = 1'b0;
            tmr_nxt = TIMER_RST;
            dcnt_nxt = TIMER_RST;
            acc_nxt = ACC_RST;
          end
          else if (!inverse)
          begin
            acc_nxt = ACC_RST;
            if (!pick_r)
            begin
              if (above)
              begin
                pick_nxt = 1'b1;
                trip_nxt = (cfg.stage_trip_delay == TIMER_RST);
                tmr_nxt = TIMER_RST;
                dcnt_nxt = TIMER_RST;
              end
            end
            else if (below)
            begin
              if (trip_r || cfg.stage_dropout_delay == TIMER_RST ||
                  (tick && dcnt_inc >= {1'b0, cfg.stage_dropout_delay}))
              begin
                pick_nxt = 1'b0;
                trip_nxt = 1'b0;
                tmr_nxt = TIMER_RST;
                dcnt_nxt = TIMER_RST;
              end
              else if (tick)
                dcnt_nxt = dcnt_inc[TIME_W-1:0];
            end
            else
            begin
              dcnt_nxt = TIMER_RST;
              if (!trip_r && tick)
              begin
                tmr_nxt = tmr_inc[TIME_W-1:0];
                if (tmr_inc >= {1'b0, cfg.stage_trip_delay})
                  trip_nxt = 1'b1;
              end
            end
          end
          else if (pick_r)
          begin
            if (mag < iop)
            begin
              pick_nxt = 1'b0;
              trip_nxt = 1'b0;
              tmr_nxt = TIMER_RST;
              if (inst_reset)
                acc_nxt = ACC_RST;
            end
            else if (tick)
            begin
              acc_nxt = acc_r + inc;
              if (!tmr_inc[TIME_W])
                tmr_nxt = tmr_inc[TIME_W-1:0];
              if ((acc_nxt >= thr && tmr_inc >= {1'b0, cfg.stage_min_trip_time}) ||
                  tmr_inc >= {1'b0, cfg.stage_curve_max_time})
                trip_nxt = 1'b1;
            end
          end
          else if (inv_start)
          begin
            pick_nxt = 1'b1;
            tmr_nxt = TIMER_RST;
          end
          else if (inst_reset)
            acc_nxt = ACC_RST;
          else if (tick)
            acc_nxt = (acc_r > dec) ? (acc_r - dec) : ACC_RST;
        end

        assign pu_nxt = inverse ? (pick_nxt && mag > start_amp) : pick_nxt;

        always_ff @(posedge i_clock)
        begin
          if (i_reset)
          begin
            pick_r <= 1'b0;
            pu_r <= 1'b0;
            trip_r <= 1'b0;
            tmr_r <= TIMER_RST;
            dcnt_r <= TIMER_RST;
            acc_r <= ACC_RST;
          end
          else
          begin
            pick_r <= pick_nxt;
            pu_r <= pu_nxt;
            trip_r <= trip_nxt;
            tmr_r <= tmr_nxt;
            dcnt_r <= dcnt_nxt;
            acc_r <= acc_nxt;
          end
        end

        assign o_phase_pickup[s][p] = pu_r;
        assign o_phase_trip[s][p] = trip_r;
      end

      assign o_stage_pickup[s] = |o_phase_pickup[s];
      assign o_stage_trip[s] = |o_phase_trip[s];
    end
  endgenerate

endmodule : phase_overcurrent_stages

`default_nettype wire

//--- logic/overcurrent_pkg.sv
// Constants, settings layout and curve table for the overcurrent stages
`default_nettype none

package overcurrent_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_STAGES = 4;
  localparam int NUM_PHASES = 3;
  localparam int MAG_W = 12;
  localparam int PU_W = 16;
  localparam int PU_FRAC = 8;
  localparam int TIME_W = 16;
  localparam int TM_W = 12;
  localparam int IOP_W = MAG_W + PU_W - PU_FRAC;
  localparam int SQ_W = 2 * IOP_W;
  localparam int ACC_W = 72;
  localparam int COEF_FRAC = 8;

  // ==========================================================
  // Levels and scaling
  localparam logic [7:0] PCT_SCALE = 8'h64;
  localparam logic [7:0] DT_RESET_PCT = 8'h60;
  localparam logic [7:0] INV_PICKUP_PCT = 8'h68;
  // Curve sums are kept in tenths of the per-tick rate
  localparam logic [3:0] X_SCALE = 4'ha;

  // ==========================================================
  // Timing: one evaluation tick per millisecond
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES_DFLT = CLK_HZ / 1_000_000 * TICK_TIME_US;

  // ==========================================================
  // Reset values
  localparam logic [TIME_W-1:0] TIMER_RST = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_RST = 72'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    CURVE_DEFINITE = 2'b00,
    CURVE_IEC_EXT = 2'b01,
    CURVE_ANSI_VERY = 2'b10,
    CURVE_ANSI_EXT = 2'b11
  } curve_t;

  typedef enum logic
  {
    RESET_INSTANT = 1'b0,
    RESET_INVERSE = 1'b1
  } reset_kind_t;

  typedef struct packed
  {
    logic stage_enable_setting;
    curve_t stage_curve_select;
    reset_kind_t stage_reset_type;
    logic [PU_W-1:0] pickup_pu;
    logic [PU_W-1:0] stage_start_current;
    logic [TIME_W-1:0] stage_trip_delay;
    logic [TIME_W-1:0] stage_dropout_delay;
    logic [TIME_W-1:0] stage_curve_max_time;
    logic [TIME_W-1:0] stage_min_trip_time;
    logic [TM_W-1:0] stage_time_multiplier;
  } stage_cfg_t;

  // A and B in hundredths, reset ratio 10*A/treset in 4.8
  typedef struct packed
  {
    logic [14:0] a_c;
    logic [7:0] b_c;
    logic [11:0] r_c;
  } curve_coef_t;

  function automatic curve_coef_t curve_coef(input curve_t c);
    curve_coef_t k;
    case (c)
      CURVE_IEC_EXT: k = '{a_c: 15'h1f40, b_c: 8'h00, r_c: 12'ha00};
      CURVE_ANSI_VERY: k = '{a_c: 15'h07a9, b_c: 8'h31, r_c: 12'h914};
      CURVE_ANSI_EXT: k = '{a_c: 15'h0b04, b_c: 8'h0c, r_c: 12'h9b1};
      default: k = '{a_c: 15'h0000, b_c: 8'h00, r_c: 12'h000};
    endcase
    return k;
  endfunction : curve_coef

endpackage : overcurrent_pkg

`default_nettype wire

//--- tb/mag_front_end.sv
// Behavioural current measurement front end
`default_nettype none

module mag_front_end
  import overcurrent_pkg::*;
(
  input wire logic i_clock,
  input wire logic [NUM_PHASES-1:0][MAG_W-1:0] i_level,
  output logic [NUM_PHASES-1:0][MAG_W-1:0] o_phase_mag
);
  timeunit 1ns;
  timeprecision 1ns;
  // A fresh magnitude per phase every clock
  always_ff @(posedge i_clock)
  begin
    o_phase_mag <= i_level;
  end
endmodule : mag_front_end

`default_nettype wire

//--- tb/phase_overcurrent_stages_asserts.sv
// Port-level checks for the overcurrent stages
`default_nettype none

module phase_overcurrent_stages_asserts
  import overcurrent_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [NUM_PHASES-1:0] i_phase_present,
  input wire stage_cfg_t i_stage_cfg [NUM_STAGES],
  input wire logic i_general_inhibit,
  input wire logic i_stage_one_inhibit,
  input wire logic i_stage_two_inhibit,
  input wire logic i_stage_three_inhibit,
  input wire logic i_stage_four_inhibit,
  input wire logic [NUM_STAGES-1:0][NUM_PHASES-1:0] o_phase_pickup,
  input wire logic [NUM_STAGES-1:0][NUM_PHASES-1:0] o_phase_trip,
  input wire logic [NUM_STAGES-1:0] o_stage_pickup,
  input wire logic [NUM_STAGES-1:0] o_stage_trip,
  input wire logic [NUM_STAGES-1:0] o_stage_inhibited_flag
);
  logic [3:0] inh;
  logic [2:0] any_pu;
  assign inh = {i_stage_four_inhibit, i_stage_three_inhibit, i_stage_two_inhibit,
    i_stage_one_inhibit};
  assign any_pu = o_phase_pickup[0] | o_phase_pickup[1] | o_phase_pickup[2] | o_phase_pickup[3];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ==========
  // Per stage
  for (genvar s = 0; s < NUM_STAGES; s++)
  begin : g_st
    or_pickup_a: assert property (o_stage_pickup[s] == |o_phase_pickup[s])
      else $error("stage pickup not phase OR");
    or_trip_a: assert property (o_stage_trip[s] == |o_phase_trip[s])
      else $error("stage trip not phase OR");
    disabled_quiet_a: assert property (!i_stage_cfg[s].stage_enable_setting |=>
      o_phase_pickup[s] == '0 && o_phase_trip[s] == '0) else $error("disabled stage active");
    inhibit_flag_a: assert property (o_stage_inhibited_flag[s] == (inh[s] | i_general_inhibit))
      else $error("inhibited flag wrong");
    inhibit_quiet_a: assert property (o_stage_inhibited_flag[s] |=>
      o_phase_trip[s] == '0 && o_phase_pickup[s] == '0) else $error("inhibited stage active");
  end
  absent_quiet_a: assert property ((any_pu & ~$past(i_phase_present)) == '0)
    else $error("absent phase picked up");
  trip_pickup_a: assert property ((o_phase_trip[0] & ~o_phase_pickup[0]) == '0)
    else $error("definite trip without pickup");
  reset_clear_a: assert property (disable iff (1'b0) i_reset |=>
    o_phase_pickup == '0 && o_phase_trip == '0) else $error("flags not cleared by reset");
  cover property (o_stage_trip[0]);
  cover property (o_stage_trip[2]);
  cover property (o_stage_trip[3]);
  cover property (i_general_inhibit && o_stage_inhibited_flag == 4'hf);
endmodule : phase_overcurrent_stages_asserts

bind phase_overcurrent_stages phase_overcurrent_stages_asserts #(.TICK_CYCLES(TICK_CYCLES))
  i_chk (.i_clock(i_clock), .i_reset(i_reset), .i_phase_present(i_phase_present),
  .i_stage_cfg(i_stage_cfg), .i_general_inhibit(i_general_inhibit),
  .i_stage_one_inhibit(i_stage_one_inhibit), .i_stage_two_inhibit(i_stage_two_inhibit),
  .i_stage_three_inhibit(i_stage_three_inhibit), .i_stage_four_inhibit(i_stage_four_inhibit),
  .o_phase_pickup(o_phase_pickup), .o_phase_trip(o_phase_trip),
  .o_stage_pickup(o_stage_pickup), .o_stage_trip(o_stage_trip),
  .o_stage_inhibited_flag(o_stage_inhibited_flag));

`default_nettype wire

//--- tb/test_phase_overcurrent_stages.sv
// Self-checking bench for the overcurrent stages
`default_nettype none

module test_phase_overcurrent_stages
  import overcurrent_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ginh, pk;
  logic [3:0] sinh;
  logic [2:0] pres;
  logic [MAG_W-1:0] rated;
  logic [NUM_PHASES-1:0][MAG_W-1:0] lvl, mag;
  stage_cfg_t cfg [NUM_STAGES];
  logic [3:0][2:0] ppu, ptr;
  logic [3:0] spu, str, sinf;
  int err_total, n_tests, m;
  real t;
  stage_cfg_t c3;
  int vals [4] = '{101, 96, 95, 100};

  mag_front_end i_mag_front_end (.i_clock(clk), .i_level(lvl), .o_phase_mag(mag));
  phase_overcurrent_stages #(.TICK_CYCLES(4)) i_phase_overcurrent_stages (.i_clock(clk),
    .i_reset(rst), .i_phase_mag(mag), .i_phase_present(pres), .i_rated_current(rated),
    .i_stage_cfg(cfg), .i_general_inhibit(ginh), .i_stage_one_inhibit(sinh[0]),
    .i_stage_two_inhibit(sinh[1]), .i_stage_three_inhibit(sinh[2]),
    .i_stage_four_inhibit(sinh[3]), .o_phase_pickup(ppu), .o_phase_trip(ptr),
    .o_stage_pickup(spu), .o_stage_trip(str), .o_stage_inhibited_flag(sinf));

  // ==========
  // Helpers
  function automatic stage_cfg_t mk(input logic en, input curve_t cv, input int d, input int dr);
    stage_cfg_t c;
    c = '0;
    c.stage_enable_setting = en;
    c.stage_curve_select = cv;
    c.pickup_pu = 16'h0100;
    c.stage_start_current = 16'h0100;
    c.stage_trip_delay = 16'(d);
    c.stage_dropout_delay = 16'(dr);
    c.stage_curve_max_time = 16'h0010;
    c.stage_time_multiplier = 12'h064;
    return c;
  endfunction : mk

  // Hysteresis band of a definite element, threshold 100 A
  function automatic logic dt_pick(input int v, input logic was);
    if (v > 100)
      return 1'b1;
    if (v * PCT_SCALE < 100 * DT_RESET_PCT)
      return 1'b0;
    return was;
  endfunction : dt_pick

  // ANSI operate time in ms for a steady current ratio r
  function automatic real ansi_ms(input real a, input real b, input real r, input real tm);
    return (a / (r * r - 1.0) + b) * tm * 1000.0;
  endfunction : ansi_ms

  task chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task drv(input int p, input int v);
    @(posedge clk);
    lvl[p] <= v[MAG_W-1:0];
  endtask : drv

  task wrap_up;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // ==========
  // Sequence
  initial
  begin
    rst = 1'b1;
    ginh = 1'b0;
    sinh = 4'h0;
    pres = 3'b011;
    rated = 12'h064;
    lvl = '0;
    pk = 1'b0;
    cfg[0] = mk(1'b1, CURVE_DEFINITE, 2, 0);
    cfg[1] = mk(1'b1, CURVE_DEFINITE, 0, 3);
    cfg[2] = mk(1'b1, CURVE_IEC_EXT, 0, 0);
    cfg[3] = mk(1'b0, CURVE_DEFINITE, 0, 0);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'he002af6d));
    drv(2, 200);
    drv(0, 101);
    settle(3);
    chk("pickup s0", 1'b1, ppu[0][0]);
    chk("trip s0", 1'b0, ptr[0][0]);
    chk("trip s1", 1'b1, ptr[1][0]);
    chk("pickup s2", 1'b0, ppu[2][0]);
    chk("pickup s3", 1'b0, ppu[3][0]);
    chk("absent", 1'b0, ppu[0][2]);
    chk("stage pickup", 1'b1, spu[0]);
    for (m = 0; m < 20 && ptr[0][0] !== 1'b1; m++) settle(1);
    // Second tick after pickup lands 5 to 8 cycles later
    chk("trip delay s0", 1'b1, m >= 4 && m <= 7);
    chk("trip s0", 1'b1, str[0]);
    drv(0, 97);
    settle(3);
    chk("hold s0", 1'b1, ppu[0][0]);
    drv(0, 95);
    settle(3);
    chk("drop s0", 1'b0, ppu[0][0] | ptr[0][0]);
    chk("drop s1", 1'b0, ppu[1][0] | ptr[1][0]);
    drv(0, 200);
    settle(3);
    chk("inv pickup", 1'b1, ppu[2][0]);
    for (int i = 0; i < 150 && ptr[2][0] !== 1'b1; i++) settle(1);
    chk("inv trip", 1'b1, ptr[2][0]);
    @(posedge clk);
    sinh[2] <= 1'b1;
    settle(2);
    chk("inh s2", 1'b1, sinf[2] & ~ppu[2][0]);
    @(posedge clk);
    sinh[2] <= 1'b0;
    ginh <= 1'b1;
    settle(2);
    chk("inh all", 1'b1, sinf[0] & ~ppu[0][0]);
    @(posedge clk);
    ginh <= 1'b0;
    cfg[3] <= mk(1'b1, CURVE_DEFINITE, 100, 3);
    settle(3);
    chk("dropout pickup", 1'b1, ppu[3][0]);
    drv(0, 50);
    settle(3);
    chk("dropout hold", 1'b1, ppu[3][0]);
    settle(16);
    chk("dropout end", 1'b0, ppu[3][0]);
    drv(0, 0);
    for (int i = 0; i < 20; i++)
    begin
      m = (i < 4) ? vals[i] : $urandom_range(150, 50);
      drv(1, m);
      settle(3);
      pk = dt_pick(m, pk);
      chk("pickup p1", pk, ppu[0][1]);
    end
    // ANSI very inverse, TM 0.01, inverse reset, twice the threshold
    c3 = mk(1'b1, CURVE_ANSI_VERY, 0, 0);
    c3.stage_curve_max_time = 16'h1000;
    c3.stage_time_multiplier = 12'h001;
    c3.stage_reset_type = RESET_INVERSE;
    t = ansi_ms(19.61, 0.491, 2.0, 0.01);
    @(posedge clk);
    cfg[3] <= c3;
    lvl[1] <= '0;
    drv(0, 200);
    for (m = 0; m < 400 && ptr[3][0] !== 1'b1; m++) settle(1);
    chk("ansi time", 1'b1, m >= 4 * t && m <= 4 * (t + 2.0));
    drv(0, 50);
    settle(3);
    chk("inv reset pu", 1'b0, ppu[3][0] | ptr[3][0]);
    settle(16);
    drv(0, 200);
    // Little has unwound, so the repeat fault trips far sooner
    for (m = 0; m < 400 && ptr[3][0] !== 1'b1; m++) settle(1);
    chk("refault sooner", 1'b1, m < 40);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset clear", 1'b0, |{ppu, ptr});
    wrap_up();
  end
endmodule : test_phase_overcurrent_stages

`default_nettype wire
